// *** core/djh_pkg.sv ***
// shared constants and types for the dispense job handshake block
package djh_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_NS;
   localparam int CABLE_LAG_MS = 100;
   localparam logic [15:0] DCOMP_HOLD_MS = 16'h01f4;
   localparam int TICK_W = 20;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SCALE = 8'h04;
   localparam logic [7:0] ADDR_OPEN_MS = 8'h08;
   localparam logic [7:0] ADDR_END_MS = 8'h0c;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_STYLE = 8'h18;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] SCALE_RST = 8'h64;
   localparam logic [15:0] OPEN_MS_RST = 16'h0032;
   localparam logic [15:0] END_MS_RST = 16'h0064;

   // ************************************************************
   // codes
   // ************************************************************
   localparam logic [7:0] STYLE_PURGE = 8'h00;
   localparam logic [7:0] STYLE_CABLE = 8'h01;
   localparam logic [3:0] VALVE1_SEL = 4'h1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_FINISH = 2'b11,
      ST_WAIT = 2'b10
   } djh_state_e;

   typedef enum logic [1:0] {
      PC_DISPLAY = 2'h0,
      PC_VALVE1 = 2'h1,
      PC_GATEWAY = 2'h2
   } djh_pcmode_e;

   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_CABLE = 2'h1,
      SRC_GATEWAY = 2'h2
   } djh_src_e;

   typedef struct packed {
      logic discrete;
      logic cmd_digital;
      logic [1:0] cmd_src;
      logic trig_cable;
      logic end_timer;
      logic [1:0] pc_mode;
   } djh_ctrl_s;

   typedef struct packed {
      logic vol_ok;
      logic no_alarm;
      logic no_error;
      logic err;
      logic [15:0] volume;
   } djh_res_s;

   typedef struct packed {
      logic strobe;
      logic complete;
      logic trig;
      logic cmd_valid;
      logic [3:0] valve_on;
      logic [3:0] pc_valve_on;
      logic [1:0] dig_cmd;
      logic [7:0] style;
      logic [15:0] cmd;
   } djh_in_s;

endpackage

// *** core/djh_style_mem.sv ***
// per-plate style table holding the static precharge pressure
`timescale 1ns/100ps
module djh_style_mem #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   // clock
   input wire logic i_mclk,
   // write side
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   // read side
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array; contents are undefined until software loads it
   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// *** core/djh_top.sv ***
// job handshake and precharge control for one fluid plate
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - display mode: job active, valves closed, hold static precharge pressure
// - dynamic: closed scaling when shut, opening scaling for set ms after opening
// - valve-one mode scales the present command with valve one scaling
// - gateway mode uses scaling of gateway-selected valves, fieldbus only
// - display and valve-one ignore request bits, precharge when no valve open
// - selected style is echoed back to the controller
// - strobe latches style, starts job, raises in-process
// - complete ends job; timer end mode also ends it on expiry
// - at job end results update, then in-process drops
// - cable trigger alone starts style one job, ended only by timer
// - complete must be pulsed; held complete raises advisory
// - strobe falling before complete raises advisory
// - strobe withdrawal or complete cancels an active strobe-started job
// - precharge request bits unused on discrete gateway systems
// - command valid honoured only for cable or gateway sources
// - digital command on discrete gateway comes from two digital inputs
// - one plate per job, each plate with its own style table
// - timer restarts on each valve-off; expires when off longer than preset
// - style zero is purge, not production
module djh_top
   import djh_pkg::*;
#(
   parameter int MS_CYC = djh_pkg::CYC_PER_MS
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // automation inputs
   input wire logic i_style_strobe,
   input wire logic i_disp_complete,
   input wire logic i_cable_trig,
   input wire logic i_cmd_valid,
   input wire logic [3:0] i_valve_on,
   input wire logic [3:0] i_pc_valve_on,
   input wire logic [1:0] i_dig_cmd,
   input wire logic [7:0] i_style,
   input wire logic [15:0] i_cmd,
   // automation outputs
   output logic o_ready,
   output logic o_in_process,
   output logic o_no_alarm,
   output logic o_no_error,
   output logic o_vol_ok,
   output logic o_error,
   output logic [15:0] o_volume,
   output logic [7:0] o_style_echo,
   output logic o_purge,
   // regulator side
   output logic o_pc_active,
   output logic [7:0] o_pc_scale,
   output logic [15:0] o_pc_psi,
   output logic [3:0] o_pc_sel,
   output logic [15:0] o_cmd_level
);
   typedef struct packed {
      djh_in_s sync1;
      djh_in_s sync2;
      djh_state_e state;
      djh_ctrl_s ctrl;
      logic [7:0] scale_closed;
      logic [7:0] scale_open;
      logic [15:0] open_ms;
      logic [15:0] end_ms;
      djh_res_s res;
      logic [7:0] job_style;
      logic from_cable;
      logic any_prev;
      logic [15:0] open_left;
      logic [15:0] end_cnt;
      logic [15:0] hold_cnt;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic adv_hold;
      logic adv_strobe;
      logic ready;
      logic in_proc;
      djh_res_s res_out;
      logic [7:0] style_echo;
      logic purge;
      logic pc_active;
      logic [7:0] pc_scale;
      logic [15:0] pc_psi;
      logic [3:0] pc_sel;
      logic [15:0] cmd_level;
      logic [31:0] rdata;
   } djh_st_s;

   djh_st_s st_reg;
   djh_st_s st_next;
   djh_in_s in_now;
   logic [15:0] mem_rdata;
   logic [7:0] mem_raddr;
   logic mem_we;

   assign in_now = '{i_style_strobe, i_disp_complete, i_cable_trig,
      i_cmd_valid, i_valve_on, i_pc_valve_on, i_dig_cmd, i_style, i_cmd};
   assign mem_we = i_wr && (i_addr == ADDR_STYLE);
   // table indexed by incoming style, or by style one when cable trigger is set, until the job latches it
   assign mem_raddr = (st_reg.state == ST_IDLE) ?
      (st_reg.ctrl.trig_cable ? STYLE_CABLE : st_reg.sync2.style) :
      st_reg.job_style;

   // ************************************************************
   // style table
   // ************************************************************
   djh_style_mem #(.AW(8), .DW(16)) u_mem (
      .i_mclk(i_mclk),
      .i_we(mem_we),
      .i_waddr(i_wdata[23:16]),
      .i_wdata(i_wdata[15:0]),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      djh_in_s in_s;
      logic any_on;
      logic valve_rise;
      logic valve_fall;
      logic timed_end;
      logic opening;
      in_s = st_reg.sync2;
      timed_end = 1'b0;
      opening = 1'b0;
      st_next = st_reg;
      st_next.sync1 = in_now;
      st_next.sync2 = st_reg.sync1;
      any_on = |in_s.valve_on;
      valve_rise = any_on && !st_reg.any_prev;
      valve_fall = !any_on && st_reg.any_prev;
      st_next.any_prev = any_on;
      st_next.tick = 1'b0;
      if (st_reg.tick_cnt == TICK_W'(MS_CYC - 1)) begin
         st_next.tick_cnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
      end

      // register writes; advisory clear is write-one, a new set wins
      if (i_wr) begin
         unique case (i_addr)
            ADDR_CTRL: st_next.ctrl = i_wdata[7:0];
            ADDR_SCALE: begin
               st_next.scale_closed = i_wdata[7:0];
               st_next.scale_open = i_wdata[15:8];
            end
            ADDR_OPEN_MS: st_next.open_ms = i_wdata[15:0];
            ADDR_END_MS: st_next.end_ms = i_wdata[15:0];
            ADDR_RESULT: st_next.res = i_wdata[19:0];
            ADDR_STATUS: begin
               if (i_wdata[0]) begin
                  st_next.adv_hold = 1'b0;
               end
               if (i_wdata[1]) begin
                  st_next.adv_strobe = 1'b0;
               end
            end
            default: ;
         endcase
      end
      st_next.rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            ADDR_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
            ADDR_SCALE: st_next.rdata = {16'h0, st_reg.scale_open,
               st_reg.scale_closed};
            ADDR_OPEN_MS: st_next.rdata = {16'h0, st_reg.open_ms};
            ADDR_END_MS: st_next.rdata = {16'h0, st_reg.end_ms};
            ADDR_RESULT: st_next.rdata = {12'h0, st_reg.res};
            ADDR_STATUS: st_next.rdata = {16'h0, st_reg.job_style,
               3'h0, st_reg.in_proc, st_reg.state, st_reg.adv_strobe,
               st_reg.adv_hold};
            default: st_next.rdata = '0;
         endcase
      end

      // command level: valid flag only matters for external sources
      if (st_reg.ctrl.cmd_src == SRC_INTERNAL || in_s.cmd_valid) begin
         if (st_reg.ctrl.cmd_digital && st_reg.ctrl.discrete) begin
            st_next.cmd_level = {in_s.dig_cmd, 14'h0};
         end else begin
            st_next.cmd_level = in_s.cmd;
         end
      end

      // ************************************************************
      // job handshake
      // ************************************************************
      st_next.ready = 1'b0;
      unique case (st_reg.state)
         ST_IDLE: begin
            st_next.ready = !in_s.strobe && !in_s.complete;
            st_next.style_echo = st_reg.ctrl.trig_cable ? STYLE_CABLE :
               in_s.style;
            if (st_reg.ctrl.trig_cable ? in_s.trig :
                (st_reg.ready && in_s.strobe)) begin
               st_next.state = ST_ACTIVE;
               st_next.in_proc = 1'b1;
               st_next.from_cable = st_reg.ctrl.trig_cable;
               st_next.job_style = st_next.style_echo;
               st_next.purge = (st_next.style_echo == STYLE_PURGE);
               st_next.end_cnt = '0;
               st_next.open_left = '0;
               st_next.ready = 1'b0;
            end
         end
         ST_ACTIVE: begin
            if (any_on || valve_fall) begin
               st_next.end_cnt = '0;
            end else if (st_reg.tick && st_reg.end_cnt <= st_reg.end_ms) begin
               st_next.end_cnt = st_reg.end_cnt + 1'b1;
            end
            timed_end = (st_reg.ctrl.end_timer || st_reg.from_cable) &&
               (st_reg.end_cnt > st_reg.end_ms);
            if (!st_reg.from_cable && in_s.complete) begin
               st_next.state = ST_FINISH;
            end else if (!st_reg.from_cable && !in_s.strobe) begin
               st_next.state = ST_FINISH;
               st_next.adv_strobe = 1'b1;
            end else if (timed_end) begin
               st_next.state = ST_FINISH;
            end
            if (st_next.state == ST_FINISH) begin
               st_next.res_out = st_reg.res;
            end
         end
         ST_FINISH: begin
            st_next.in_proc = 1'b0;
            st_next.purge = 1'b0;
            st_next.hold_cnt = '0;
            st_next.state = ST_WAIT;
         end
         ST_WAIT: begin
            if (in_s.complete && st_reg.tick) begin
               st_next.hold_cnt = st_reg.hold_cnt + 1'b1;
            end
            // only a complete still held re-arms the advisory after a clear
            if (in_s.complete && st_reg.hold_cnt >= DCOMP_HOLD_MS) begin
               st_next.adv_hold = 1'b1;
            end
            if (!in_s.strobe && !in_s.complete && !in_s.trig) begin
               st_next.state = ST_IDLE;
            end
         end
      endcase

      // ************************************************************
      // precharge
      // ************************************************************
      if (valve_rise) begin
         st_next.open_left = st_reg.open_ms;
      end else if (st_reg.tick && st_reg.open_left != '0) begin
         st_next.open_left = st_reg.open_left - 1'b1;
      end
      opening = any_on && (st_reg.open_left != '0 || valve_rise);
      st_next.pc_active = 1'b0;
      st_next.pc_scale = '0;
      st_next.pc_sel = '0;
      st_next.pc_psi = mem_rdata;
      if (st_reg.state == ST_ACTIVE) begin
         if (st_reg.ctrl.pc_mode == PC_GATEWAY && !st_reg.ctrl.discrete) begin
            st_next.pc_active = |in_s.pc_valve_on;
            st_next.pc_sel = in_s.pc_valve_on;
            st_next.pc_scale = opening ? st_reg.scale_open :
               st_reg.scale_closed;
         end else if (st_reg.ctrl.pc_mode == PC_VALVE1) begin
            st_next.pc_active = !any_on || opening;
            st_next.pc_sel = VALVE1_SEL;
            st_next.pc_scale = opening ? st_reg.scale_open :
               st_reg.scale_closed;
         end else begin
            // gateway on a discrete system falls back to display
            st_next.pc_active = !any_on;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st_reg <= '{state: ST_IDLE, ctrl: CTRL_RST, scale_closed: SCALE_RST,
            scale_open: SCALE_RST, open_ms: OPEN_MS_RST, end_ms: END_MS_RST,
            default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata = st_reg.rdata;
   assign o_ready = st_reg.ready;
   assign o_in_process = st_reg.in_proc;
   assign o_no_alarm = st_reg.res_out.no_alarm;
   assign o_no_error = st_reg.res_out.no_error;
   assign o_vol_ok = st_reg.res_out.vol_ok;
   assign o_error = st_reg.res_out.err;
   assign o_volume = st_reg.res_out.volume;
   assign o_style_echo = st_reg.style_echo;
   assign o_purge = st_reg.purge;
   assign o_pc_active = st_reg.pc_active;
   assign o_pc_scale = st_reg.pc_scale;
   assign o_pc_psi = st_reg.pc_psi;
   assign o_pc_sel = st_reg.pc_sel;
   assign o_cmd_level = st_reg.cmd_level;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   job_start_a: assert property (
      st_reg.state == ST_IDLE && st_reg.ready && !st_reg.ctrl.trig_cable &&
      st_reg.sync2.strobe |=> o_in_process && st_reg.state == ST_ACTIVE &&
      st_reg.job_style == $past(st_reg.sync2.style))
      else $error("job did not start on strobe");
   complete_end_a: assert property (
      st_reg.state == ST_ACTIVE && !st_reg.from_cable &&
      st_reg.sync2.complete |=> st_reg.state == ST_FINISH)
      else $error("complete did not end the job");
   result_order_a: assert property (
      st_reg.state == ST_FINISH |-> o_in_process &&
      o_vol_ok == st_reg.res.vol_ok ##1 !o_in_process)
      else $error("results not ahead of in-process drop");
   strobe_cancel_a: assert property (
      st_reg.state == ST_ACTIVE && !st_reg.from_cable &&
      !st_reg.sync2.complete && !st_reg.sync2.strobe |=>
      st_reg.state == ST_FINISH && st_reg.adv_strobe)
      else $error("early strobe drop not handled");
   display_hold_a: assert property (
      st_reg.state == ST_ACTIVE && st_reg.ctrl.pc_mode == PC_DISPLAY &&
      st_reg.sync2.valve_on == 4'h0 |=> o_pc_active &&
      o_pc_psi == $past(mem_rdata))
      else $error("static precharge not held");
   open_scale_a: assert property (
      st_reg.state == ST_ACTIVE && st_reg.ctrl.pc_mode == PC_VALVE1 &&
      !st_reg.any_prev && st_reg.sync2.valve_on != 4'h0 &&
      st_reg.open_ms != '0 |=> o_pc_scale == st_reg.scale_open && o_pc_active)
      else $error("opening scaling not applied");
   cable_style_a: assert property (
      st_reg.state == ST_IDLE && st_reg.ctrl.trig_cable &&
      st_reg.sync2.trig |=> st_reg.job_style == STYLE_CABLE && o_in_process)
      else $error("cable job not style one");
   discrete_gw_a: assert property (
      st_reg.ctrl.discrete && st_reg.ctrl.pc_mode == PC_GATEWAY |=>
      o_pc_sel == 4'h0)
      else $error("request bits used on discrete system");
   timer_end_a: assert property (
      st_reg.state == ST_ACTIVE && st_reg.ctrl.end_timer &&
      !st_reg.sync2.complete && st_reg.sync2.strobe &&
      st_reg.end_cnt > st_reg.end_ms |=> st_reg.state == ST_FINISH)
      else $error("job timer expiry missed");

   job_done_c: cover property (st_reg.state == ST_FINISH ##1 !o_in_process);
   cable_job_c: cover property (st_reg.from_cable && st_reg.state == ST_FINISH);
   hold_adv_c: cover property ($rose(st_reg.adv_hold));
endmodule

// *** bench/djh_auto_model.sv ***
// behavioural automation controller facing the job handshake
`timescale 1ns/100ps
module djh_auto_model #(
   parameter int GAP = 4,
   parameter int JOB_GAP = 20
) (
   // clock
   input wire logic i_mclk,
   // device outputs
   input wire logic i_ready,
   // controller outputs
   output logic o_strobe,
   output logic o_complete,
   output logic [3:0] o_valve_on,
   output logic [7:0] o_style
);
   initial begin
      o_strobe = 1'b0;
      o_complete = 1'b0;
      o_valve_on = 4'h0;
      o_style = 8'h5a;
   end
   // gaps are scaled down from the ms figures to keep the run short
   task automatic pause(input int c);
      repeat (c) @(posedge i_mclk);
   endtask
   // ok stays low if the device never became ready
   task automatic start_job(input logic [7:0] s, output logic ok);
      int n;
      n = 0;
      pause(JOB_GAP);
      while (i_ready !== 1'b1 && n < 200) begin
         @(posedge i_mclk);
         n++;
      end
      ok = (i_ready === 1'b1);
      o_style <= s;
      pause(GAP);
      o_strobe <= 1'b1;
   endtask
   task automatic set_valves(input logic [3:0] v);
      o_valve_on <= v;
   endtask
   task automatic set_complete(input logic v);
      o_complete <= v;
   endtask
   // complete is pulsed, then the strobe is released after it
   task automatic end_job(input int hold);
      o_complete <= 1'b1;
      pause(hold);
      o_complete <= 1'b0;
      pause(GAP);
      o_strobe <= 1'b0;
      o_style <= ~o_style;
   endtask
   task automatic drop_strobe();
      o_strobe <= 1'b0;
   endtask
endmodule

// *** bench/djh_top_tb.sv ***
// self-checking bench for the dispense job handshake block
`timescale 1ns/100ps
module djh_top_tb;
   import djh_pkg::*;
   logic i_mclk, i_rstn, i_wr, i_rd, i_cable_trig, i_cmd_valid;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0] i_pc_valve_on, valve_on, o_pc_sel;
   logic [1:0] i_dig_cmd;
   logic [15:0] i_cmd, o_volume, o_pc_psi, o_cmd_level;
   logic strobe, complete, o_ready, o_in_process, o_no_alarm, o_no_error;
   logic o_vol_ok, o_error, o_purge, o_pc_active;
   logic [7:0] style, o_style_echo, o_pc_scale;
   int fails = 0;
   int checks_done = 0;

   djh_top #(.MS_CYC(10)) dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_style_strobe(strobe),
      .i_disp_complete(complete), .i_cable_trig(i_cable_trig),
      .i_cmd_valid(i_cmd_valid), .i_valve_on(valve_on),
      .i_pc_valve_on(i_pc_valve_on), .i_dig_cmd(i_dig_cmd),
      .i_style(style), .i_cmd(i_cmd), .o_ready(o_ready),
      .o_in_process(o_in_process), .o_no_alarm(o_no_alarm),
      .o_no_error(o_no_error), .o_vol_ok(o_vol_ok), .o_error(o_error),
      .o_volume(o_volume), .o_style_echo(o_style_echo), .o_purge(o_purge),
      .o_pc_active(o_pc_active), .o_pc_scale(o_pc_scale),
      .o_pc_psi(o_pc_psi), .o_pc_sel(o_pc_sel), .o_cmd_level(o_cmd_level));

   djh_auto_model ctl_u (.i_mclk(i_mclk), .i_ready(o_ready),
      .o_strobe(strobe), .o_complete(complete), .o_valve_on(valve_on),
      .o_style(style));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic report_and_stop();
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask
   // read data is taken in the one cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(posedge i_mclk);
      chk(o_rdata & m, exp);
   endtask
   task automatic wait_ip(input logic v, input int lim);
      int n;
      n = 0;
      while (o_in_process !== v && n < lim) begin
         @(posedge i_mclk);
         n++;
      end
      chk({31'h0, o_in_process}, {31'h0, v});
   endtask
   task automatic go(input logic [7:0] s);
      logic ok;
      ctl_u.start_job(s, ok);
      chk({31'h0, ok}, 32'h1);
      wait_ip(1'b1, 10);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic s_reset();
      chk({31'h0, o_in_process}, 32'h0);
      rd(ADDR_CTRL, 32'hffffffff, 32'h0);
      rd(ADDR_SCALE, 32'hffffffff, 32'h6464);
      rd(ADDR_OPEN_MS, 32'hffffffff, 32'h32);
      rd(ADDR_END_MS, 32'hffffffff, 32'h64);
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c, 32'hffffffff, 32'h0);
      rd(ADDR_STYLE, 32'hffffffff, 32'h0);
      // load styles 0 to 4 for the later display-mode jobs; s_display loads its own style 7
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_STYLE, {8'h0, 8'(k), 16'h0200});
      end
   endtask
   task automatic s_display();
      wr(ADDR_STYLE, 32'h0007_0123);
      wr(ADDR_RESULT, 32'h000b_0abc);
      go(8'h07);
      ctl_u.pause(4);
      chk({24'h0, o_style_echo}, 32'h7);
      chk({15'h0, o_pc_active, o_pc_psi}, 32'h1_0123);
      ctl_u.set_valves(4'h1);
      ctl_u.pause(5);
      chk({31'h0, o_pc_active}, 32'h0);
      ctl_u.set_valves(4'h0);
      ctl_u.pause(5);
      chk({31'h0, o_pc_active}, 32'h1);
      ctl_u.end_job(6);
      wait_ip(1'b0, 10);
      chk({12'h0, o_vol_ok, o_no_alarm, o_no_error, o_error, o_volume},
          32'h000b_0abc);
      ctl_u.pause(6);
      rd(ADDR_STATUS, 32'hff1f, 32'h0700);
   endtask
   task automatic s_early();
      go(STYLE_PURGE);
      ctl_u.pause(2);
      chk({31'h0, o_purge}, 32'h1);
      chk({15'h0, o_pc_active, o_pc_psi}, 32'h1_0200);
      ctl_u.drop_strobe();
      wait_ip(1'b0, 10);
      rd(ADDR_STATUS, 32'h3, 32'h2);
      wr(ADDR_STATUS, 32'h2);
      rd(ADDR_STATUS, 32'h3, 32'h0);
   endtask
   task automatic s_held();
      go(8'h04);
      ctl_u.pause(3);
      ctl_u.set_complete(1'b1);
      wait_ip(1'b0, 10);
      ctl_u.pause(4950);
      rd(ADDR_STATUS, 32'h1, 32'h0);
      chk({31'h0, o_ready}, 32'h0);
      ctl_u.pause(80);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      ctl_u.set_complete(1'b0);
      ctl_u.pause(4);
      ctl_u.drop_strobe();
      wr(ADDR_STATUS, 32'h3);
      rd(ADDR_STATUS, 32'h3, 32'h0);
   endtask
   // a second opening must restart the count, else the job ends early
   task automatic s_timer();
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_END_MS, 32'h5);
      go(8'h02);
      ctl_u.set_valves(4'h1);
      ctl_u.pause(20);
      ctl_u.set_valves(4'h0);
      ctl_u.pause(30);
      ctl_u.set_valves(4'h1);
      ctl_u.pause(5);
      ctl_u.set_valves(4'h0);
      ctl_u.pause(45);
      chk({31'h0, o_in_process}, 32'h1);
      wait_ip(1'b0, 40);
      ctl_u.drop_strobe();
   endtask
   task automatic s_cable();
      wr(ADDR_CTRL, 32'hc);
      wr(ADDR_END_MS, 32'h3);
      ctl_u.pause(8);
      i_cable_trig <= 1'b1;
      wait_ip(1'b1, 10);
      chk({24'h0, o_style_echo}, {24'h0, STYLE_CABLE});
      ctl_u.pause(25);
      chk({31'h0, o_in_process}, 32'h1);
      wait_ip(1'b0, 40);
      i_cable_trig <= 1'b0;
   endtask
   task automatic s_scaling();
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_SCALE, 32'h7850);
      wr(ADDR_OPEN_MS, 32'h3);
      go(8'h09);
      ctl_u.pause(4);
      chk({19'h0, o_pc_active, o_pc_sel, o_pc_scale},
          {19'h0, 1'b1, VALVE1_SEL, 8'h50});
      ctl_u.set_valves(4'h4);
      ctl_u.pause(5);
      chk({24'h0, o_pc_scale}, 32'h78);
      ctl_u.set_valves(4'h0);
      ctl_u.end_job(6);
      wait_ip(1'b0, 10);
      wr(ADDR_CTRL, 32'h2);
      i_pc_valve_on <= 4'h6;
      go(8'h0a);
      ctl_u.pause(4);
      chk({28'h0, o_pc_sel}, 32'h6);
      ctl_u.end_job(6);
      wait_ip(1'b0, 10);
   endtask
   task automatic s_cmd();
      wr(ADDR_CTRL, 32'h10);
      i_cmd <= 16'h1234;
      i_cmd_valid <= 1'b1;
      ctl_u.pause(5);
      chk({16'h0, o_cmd_level}, 32'h1234);
      i_cmd_valid <= 1'b0;
      i_cmd <= 16'h4321;
      ctl_u.pause(5);
      chk({16'h0, o_cmd_level}, 32'h1234);
      wr(ADDR_CTRL, 32'h0);
      ctl_u.pause(5);
      chk({16'h0, o_cmd_level}, 32'h4321);
      i_dig_cmd <= 2'h2;
      wr(ADDR_CTRL, 32'hc2);
      ctl_u.pause(5);
      chk({16'h0, o_cmd_level}, 32'h8000);
   endtask

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   initial begin
      repeat (40000) @(posedge i_mclk);
      fails++;
      report_and_stop();
   end
   initial begin
      i_rstn = 1'b0;
      i_addr = 8'h0;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_cable_trig = 1'b0;
      i_cmd_valid = 1'b0;
      i_pc_valve_on = 4'h0;
      i_dig_cmd = 2'h0;
      i_cmd = 16'h0;
      repeat (3) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      s_reset();
      s_display();
      s_early();
      s_held();
      s_timer();
      s_cable();
      s_scaling();
      s_cmd();
      report_and_stop();
   end
endmodule
